// file: design/power_mode_and_reset_control.sv
// Purpose: idle and power-down control plus reset source sequencing
// Assumes: rst_n_in is the power-on reset from the supply monitor
// Notes: registers on APB, one wait state, answer one cycle into access phase
//
// Functional notes
// - idle bit set enters idle immediately
// - idle stops only the cpu clock
// - idle: strobes high, ports held
// - enabled interrupt clears idle bit, resumes
// - reset during idle restarts at zero, no delay
// - power-down bit set stops all clocks
// - power-down: strobes low, ports show registers
// - pin or power-on reset ends power-down
// - enabled external interrupt wakes power-down
// - reset pin sampled in fourth state, twice
// - reset held while pin high, two cycles after
// - power-on reset sets power-on flag
// - watchdog timeout flag, 512 clocks, reset
// - reset image: pc zero, sp 07, ports FF
// - on-chip memory untouched; only the pc, sp and port image is loaded
// - watchdog control reset values per source
// - reset flag, power-on flag, enable per source
// - protected watchdog bits need timed access
// - machine cycle is four clock states
//
// The APB register port was left to the implementer.
module power_mode_and_reset_control
    import power_reset_pkg::*;
(
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic reset_pin_in,
    input wire logic [1:0] ext_int_n_in,
    input wire logic ext_code_in,
    input wire logic irq_wake_in,
    input wire logic timed_access_open_in,
    input wire logic wdt_timeout_in,
    input wire logic wdt_clear_in,
    input wire logic ale_core_in,
    input wire logic store_strobe_core_in,
    output logic cpu_clock_en_out,
    output logic periph_clock_en_out,
    output logic core_reset_out,
    output reset_image_s reset_image_out,
    output pin_ctrl_s pin_ctrl_out,
    output logic wdt_restart_out,
    output logic [1:0] machine_state_out
);
    // ****************************************
    // declarations
    // ****************************************
    logic [3:0] pin_sync1;
    logic [3:0] pin_sync2;
    logic [1:0] int_prev;
    logic reset_pin;
    logic ext_code;
    logic [1:0] int_level;
    logic [1:0] int_fall;
    logic [1:0] state;
    logic fourth_state;
    mode_e mode;
    mode_e next_mode;
    logic [7:0] power_control;
    logic [7:0] watchdog_control;
    logic [7:0] wake_config;
    logic [1:0] high_count;
    logic [1:0] tail_count;
    logic ext_hold;
    logic grace_run;
    logic [9:0] grace_count;
    logic wdt_hold;
    logic [3:0] hold_count;
    logic reset_any;
    logic [1:0] wake_hit;
    logic pd_wake;
    logic access;
    logic mapped;
    logic wr_strobe;
    logic [9:0] index;
    logic [7:0] wdata;
    logic [7:0] read_value;

    // ****************************************
    // pin synchronisers
    // ****************************************
    // two flops before anything reads a pin
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pin_sync1 <= 4'hC;
            pin_sync2 <= 4'hC;
        end else begin
            pin_sync1 <= {ext_int_n_in, ext_code_in, reset_pin_in};
            pin_sync2 <= pin_sync1;
        end
    end

    // previous interrupt level, taken from the second flop only
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            int_prev <= 2'h3;
        end else begin
            int_prev <= pin_sync2[3:2];
        end
    end

    assign reset_pin = pin_sync2[0];
    assign ext_code = pin_sync2[1];
    assign int_level = ~pin_sync2[3:2];
    assign int_fall = int_prev & ~pin_sync2[3:2];

    // ****************************************
    // machine state counter
    // ****************************************
    // frozen in power-down since the oscillator is stopped there
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state <= 2'h0;
        end else if (mode != MODE_POWER_DOWN) begin
            state <= state + 2'h1;
        end
    end

    assign fourth_state = (state == FOURTH_STATE);
    assign reset_any = ext_hold | wdt_hold;

    // ****************************************
    // external reset pin
    // ****************************************
    // sampled only in the fourth state; needs the clock running
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            high_count <= 2'h0;
            tail_count <= 2'h0;
            ext_hold <= 1'b0;
        end else if (fourth_state && mode != MODE_POWER_DOWN) begin
            if (reset_pin) begin
                tail_count <= 2'h0;
                if (high_count != RST_PIN_CYCLES) begin
                    high_count <= high_count + 2'h1;
                end
                if (high_count == RST_PIN_CYCLES - 2'h1) begin
                    ext_hold <= 1'b1;
                end
            end else begin
                high_count <= 2'h0;
                if (ext_hold) begin
                    if (tail_count == RST_TAIL_CYCLES - 2'h1) begin
                        ext_hold <= 1'b0;
                        tail_count <= 2'h0;
                    end else begin
                        tail_count <= tail_count + 2'h1;
                    end
                end
            end
        end
    end

    // ****************************************
    // watchdog reset sequencing
    // ****************************************
    // grace window after timeout, then a held reset
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            grace_run <= 1'b0;
            grace_count <= 10'h000;
            wdt_hold <= 1'b0;
            hold_count <= 4'h0;
        end else if (mode != MODE_POWER_DOWN) begin
            if (wdt_hold) begin
                if (hold_count == WDT_HOLD_CLOCKS - 4'h1) begin
                    wdt_hold <= 1'b0;
                end
                hold_count <= hold_count + 4'h1;
            end
            if (wdt_clear_in || wdt_restart_out || ext_hold) begin
                grace_run <= 1'b0;
            end else if (wdt_timeout_in && !grace_run) begin
                grace_run <= 1'b1;
                grace_count <= 10'h000;
            end else if (grace_run) begin
                grace_count <= grace_count + 10'h001;
                if (grace_count == WDT_GRACE_CLOCKS - 10'h001) begin
                    grace_run <= 1'b0;
                    if (watchdog_control[WC_RESET_ENABLE_BIT]) begin
                        wdt_hold <= 1'b1;
                        hold_count <= 4'h0;
                    end
                end
            end
        end
    end

    // ****************************************
    // power mode machine
    // ****************************************
    // only the external interrupt path or the reset pin can wake power-down
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            wake_hit[i] = wake_config[WK_ENABLE_LSB + i] &&
                (wake_config[WK_EDGE_LSB + i] ? int_fall[i] : int_level[i]);
        end
        pd_wake = wake_config[WK_GLOBAL_BIT] && (|wake_hit);
    end

    always_comb begin
        next_mode = mode;
        unique case (mode)
            MODE_RUN: begin
                if (power_control[PC_POWER_DOWN_BIT]) begin
                    next_mode = MODE_POWER_DOWN;
                end else if (power_control[PC_IDLE_BIT]) begin
                    next_mode = MODE_IDLE;
                end
            end
            MODE_IDLE: begin
                if (irq_wake_in) begin
                    next_mode = MODE_RUN;
                end
            end
            MODE_POWER_DOWN: begin
                if (reset_pin || pd_wake) begin
                    next_mode = MODE_RUN;
                end
            end
        endcase
        if (reset_any) begin
            next_mode = MODE_RUN;
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mode <= MODE_RUN;
        end else begin
            mode <= next_mode;
        end
    end

    // ****************************************
    // clock gating and pin control
    // ****************************************
    // idle keeps the peripheral clocks so interrupts can still arrive
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cpu_clock_en_out <= 1'b1;
            periph_clock_en_out <= 1'b1;
        end else begin
            cpu_clock_en_out <= (next_mode == MODE_RUN);
            periph_clock_en_out <= (next_mode != MODE_POWER_DOWN);
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pin_ctrl_out <= '0;
        end else begin
            unique case (next_mode)
                MODE_IDLE: begin
                    pin_ctrl_out <= {1'b1, 1'b1, 1'b1, ext_code, ext_code};
                end
                MODE_POWER_DOWN: begin
                    pin_ctrl_out <= {1'b0, 1'b0, 1'b0, ext_code, 1'b0};
                end
                default: begin
                    pin_ctrl_out <= {ale_core_in, store_strobe_core_in, 3'b000};
                end
            endcase
        end
    end

    // ****************************************
    // reset outputs
    // ****************************************
    // memory is not touched here; only the image below is loaded
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            core_reset_out <= 1'b1;
            reset_image_out <= {PC_RESET, SP_RESET, PORT_RESET};
            machine_state_out <= 2'h0;
        end else begin
            core_reset_out <= reset_any;
            reset_image_out <= {PC_RESET, SP_RESET, PORT_RESET};
            machine_state_out <= state;
        end
    end

    // ****************************************
    // apb slave
    // ****************************************
    assign access = psel_in && penable_in && pready_out;
    assign index = paddr_in[11:2];
    assign mapped = (paddr_in[1:0] == 2'h0) && (index == IDX_POWER_CONTROL ||
        index == IDX_WATCHDOG_CONTROL || index == IDX_WAKE_CONFIG);
    assign wr_strobe = access && pwrite_in && mapped;
    assign wdata = pwdata_in[7:0];

    always_comb begin
        read_value = 8'h00;
        if (index == IDX_POWER_CONTROL) begin
            read_value = power_control;
        end else if (index == IDX_WATCHDOG_CONTROL) begin
            read_value = watchdog_control;
        end else if (index == IDX_WAKE_CONFIG) begin
            read_value = wake_config;
        end
    end

    // one wait state keeps every answer coming from a flop
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out <= 32'h0000_0000;
        end else begin
            pready_out <= psel_in && penable_in && !pready_out;
            pslverr_out <= psel_in && penable_in && !pready_out && !mapped;
            if (psel_in && penable_in && !pready_out) begin
                prdata_out <= mapped ? {24'h00_0000, read_value} : 32'h0000_0000;
            end
        end
    end

    // ****************************************
    // power control register
    // ****************************************
    // wake clears the mode bit; a reset clears both
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            power_control <= POWER_CONTROL_RESET;
        end else if (reset_any) begin
            power_control <= POWER_CONTROL_RESET;
        end else begin
            if (wr_strobe && index == IDX_POWER_CONTROL) begin
                power_control <= wdata;
            end else if (mode == MODE_IDLE && irq_wake_in) begin
                power_control[PC_IDLE_BIT] <= 1'b0;
            end else if (mode == MODE_POWER_DOWN && (pd_wake || reset_pin)) begin
                power_control[PC_POWER_DOWN_BIT] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wake_config <= WAKE_CONFIG_RESET;
        end else if (reset_any) begin
            wake_config <= WAKE_CONFIG_RESET;
        end else if (wr_strobe && index == IDX_WAKE_CONFIG) begin
            wake_config <= wdata;
        end
    end

    // ****************************************
    // watchdog control register
    // ****************************************
    // power-on value clears reset flag and enable, sets power-on flag
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            watchdog_control <= WC_POWER_ON_VALUE;
        end else if (wdt_hold) begin
            watchdog_control <= (watchdog_control & WC_EXT_KEEP_MASK) |
                (8'h01 << WC_RESET_FLAG_BIT);
        end else if (ext_hold) begin
            watchdog_control <= watchdog_control & WC_EXT_KEEP_MASK;
        end else begin
            if (wr_strobe && index == IDX_WATCHDOG_CONTROL) begin
                if (timed_access_open_in) begin
                    watchdog_control <= wdata & (WC_FREE_MASK | WC_PROTECTED_MASK) &
                        ~(8'h01 << WC_RESTART_BIT);
                end else begin
                    watchdog_control <= (watchdog_control & ~WC_FREE_MASK) |
                        (wdata & WC_FREE_MASK);
                end
            end
            // hardware set beats a same-cycle clear
            if (wdt_timeout_in && mode != MODE_POWER_DOWN) begin
                watchdog_control[WC_TIMEOUT_BIT] <= 1'b1;
            end
        end
    end

    // restart is a write-only strobe toward the watchdog counter
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wdt_restart_out <= 1'b0;
        end else begin
            wdt_restart_out <= wr_strobe && index == IDX_WATCHDOG_CONTROL &&
                timed_access_open_in && !reset_any && wdata[WC_RESTART_BIT];
        end
    end
endmodule

// file: design/power_reset_pkg.sv
// Purpose: shared constants and types for the power and reset control block
// Assumes: byte address of a register is four times its index
// Notes: machine cycle of four clock states; CLOCKS counts are in clock_in cycles, CYCLES counts in machine cycles
package power_reset_pkg;
    // ****************************************
    // register indices, reset values and power control bits
    // ****************************************
    localparam logic [9:0] IDX_POWER_CONTROL = 10'h087;
    localparam logic [9:0] IDX_WATCHDOG_CONTROL = 10'h0D8;
    localparam logic [9:0] IDX_WAKE_CONFIG = 10'h0F0;
    localparam logic [7:0] POWER_CONTROL_RESET = 8'h00;
    localparam logic [7:0] WAKE_CONFIG_RESET = 8'h00;
    localparam int PC_IDLE_BIT = 0;
    localparam int PC_POWER_DOWN_BIT = 1;
    // ****************************************
    // watchdog control fields
    // ****************************************
    localparam int WC_POWER_ON_BIT = 6;
    localparam int WC_TIMEOUT_BIT = 3;
    localparam int WC_RESET_FLAG_BIT = 2;
    localparam int WC_RESET_ENABLE_BIT = 1;
    localparam int WC_RESTART_BIT = 0;
    localparam logic [7:0] WC_PROTECTED_MASK = 8'h4B;
    localparam logic [7:0] WC_FREE_MASK = 8'h84;
    localparam logic [7:0] WC_EXT_KEEP_MASK = 8'h46;
    localparam logic [7:0] WC_POWER_ON_VALUE = 8'h40;
    // ****************************************
    // wake configuration fields
    // ****************************************
    localparam int WK_ENABLE_LSB = 0;
    localparam int WK_EDGE_LSB = 2;
    localparam int WK_GLOBAL_BIT = 7;
    // ****************************************
    // timing
    // ****************************************
    localparam logic [1:0] FOURTH_STATE = 2'h3;
    localparam int STATES_PER_CYCLE = 4;
    localparam logic [1:0] RST_PIN_CYCLES = 2'h2;
    localparam logic [1:0] RST_TAIL_CYCLES = 2'h2;
    localparam int WDT_HOLD_CYCLES = 2;
    localparam logic [9:0] WDT_GRACE_CLOCKS = 10'd512;
    localparam logic [3:0] WDT_HOLD_CLOCKS = 4'(WDT_HOLD_CYCLES * STATES_PER_CYCLE);
    // ****************************************
    // reset image
    // ****************************************
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [7:0] SP_RESET = 8'h07;
    localparam logic [7:0] PORT_RESET = 8'hFF;
    typedef enum logic [1:0] {MODE_RUN, MODE_IDLE, MODE_POWER_DOWN} mode_e;
    typedef struct packed {
        logic ale;
        logic store_strobe;
        logic port_hold;
        logic port0_float;
        logic port2_address;
    } pin_ctrl_s;
    typedef struct packed {
        logic [15:0] pc;
        logic [7:0] sp;
        logic [7:0] port;
    } reset_image_s;
endpackage

// file: verification/power_reset_checker.sv
// Purpose: port level checks for the power and reset controller
// Assumes: bound to power_mode_and_reset_control from tb
// Notes: mode is read from the two clock enables
module power_reset_checker
    import power_reset_pkg::*;
(
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic pready_out,
    input wire logic reset_pin_in,
    input wire logic irq_wake_in,
    input wire logic timed_access_open_in,
    input wire logic cpu_clock_en_out,
    input wire logic periph_clock_en_out,
    input wire logic core_reset_out,
    input wire reset_image_s reset_image_out,
    input wire pin_ctrl_s pin_ctrl_out,
    input wire logic wdt_restart_out,
    input wire logic [1:0] machine_state_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);
    // writes during internal reset are lost, so they are left out
    wire logic take = psel_in && penable_in && pready_out && pwrite_in && !core_reset_out;
    wire logic pc_wr = take && paddr_in == {IDX_POWER_CONTROL, 2'h0};
    wire logic wc_wr = take && paddr_in == {IDX_WATCHDOG_CONTROL, 2'h0};
    wire logic idle = !cpu_clock_en_out && periph_clock_en_out;
    sequence pin_high16;
        reset_pin_in [*8] ##1 reset_pin_in [*8];
    endsequence
    sequence pin_low16;
        !reset_pin_in [*8] ##1 !reset_pin_in [*8];
    endsequence
    a_idle_entry: assert property (pc_wr && pwdata_in[0] && !pwdata_in[1] |-> ##2 idle)
        else $error("idle not entered");
    a_pd_entry: assert property (pc_wr && pwdata_in[1] |-> ##2
        !periph_clock_en_out && !cpu_clock_en_out) else $error("power-down not entered");
    a_idle_pins: assert property (idle |-> pin_ctrl_out.ale && pin_ctrl_out.store_strobe
        && pin_ctrl_out.port_hold) else $error("idle pins wrong");
    a_pd_pins: assert property (!periph_clock_en_out |-> !pin_ctrl_out.ale
        && !pin_ctrl_out.store_strobe && !pin_ctrl_out.port2_address) else $error("pd pins wrong");
    a_idle_wake: assert property (idle && irq_wake_in && !core_reset_out |=> cpu_clock_en_out)
        else $error("idle not left on interrupt");
    a_pin_reset: assert property (pin_high16 |-> ##[0:8] core_reset_out)
        else $error("pin reset not applied");
    a_reset_tail: assert property (core_reset_out ##0 pin_low16 |-> !core_reset_out)
        else $error("reset held too long");
    a_reset_image: assert property (reset_image_out == {PC_RESET, SP_RESET, PORT_RESET})
        else $error("reset image wrong");
    a_restart_gate: assert property (wc_wr && pwdata_in[WC_RESTART_BIT] |=>
        wdt_restart_out == $past(timed_access_open_in)) else $error("restart gate wrong");
    a_state_step: assert property (periph_clock_en_out && $past(periph_clock_en_out, 2)
        && !core_reset_out && !$past(core_reset_out)
        |-> machine_state_out == 2'($past(machine_state_out) + 2'h1)) else $error("state skip");
endmodule

// file: verification/reset_pin_model.sv
// Purpose: board side of the reset pin and external interrupt pins
// Assumes: pin idles low, interrupt lines pulled up
// Notes: driven just after rising edges only
module reset_pin_model (
    input wire logic clock_in,
    output logic reset_pin_out,
    output logic [1:0] ext_int_n_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // pull resistors set the idle levels
    initial begin
        reset_pin_out = 1'h0;
        ext_int_n_out = 2'h3;
    end
    // never shorter than two machine cycles, or the pin is ignored
    task automatic hold_reset(input int clocks);
        int n;
        n = (clocks < 8) ? 8 : clocks;
        @(posedge clock_in);
        reset_pin_out <= 1'h1;
        repeat (n) @(posedge clock_in);
        reset_pin_out <= 1'h0;
    endtask
    // low level on one line, then released to the pull-up
    task automatic pull_int(input int line, input int clocks);
        @(posedge clock_in);
        ext_int_n_out[line] <= 1'h0;
        repeat (clocks) @(posedge clock_in);
        ext_int_n_out[line] <= 1'h1;
    endtask
endmodule

// file: verification/tb.sv
// Purpose: self-checking bench for power modes and reset sources
// Assumes: APB master here, board pins from reset_pin_model
// Notes: watchdog clear input stays low; grace window is run in full
module tb;
    import power_reset_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [11:0] A_PC = {IDX_POWER_CONTROL, 2'h0};
    localparam logic [11:0] A_WC = {IDX_WATCHDOG_CONTROL, 2'h0};
    localparam logic [11:0] A_WK = {IDX_WAKE_CONFIG, 2'h0};
    logic clock_in = 1'h0;
    logic rst_n_in = 1'h0;
    logic psel_in = 1'h0, penable_in = 1'h0, pwrite_in = 1'h0, err;
    logic [11:0] paddr_in = 12'h000;
    logic [31:0] pwdata_in = 32'h0, prdata_out, rd;
    logic irq_wake_in = 1'h0, timed_access_open_in = 1'h0, wdt_timeout_in = 1'h0;
    logic wdt_clear_in = 1'h0, ale_core_in = 1'h1, store_strobe_core_in = 1'h0;
    logic ext_code_in = 1'h0, reset_pin_in, pready_out, pslverr_out;
    logic cpu_clock_en_out, periph_clock_en_out, core_reset_out, wdt_restart_out;
    logic [1:0] ext_int_n_in, machine_state_out;
    reset_image_s reset_image_out;
    pin_ctrl_s pin_ctrl_out;
    int error_cnt = 0, cmp_count = 0, cyc = 0, seen = 0, t0 = 0;
    always #20 clock_in = ~clock_in;
    always @(posedge clock_in) cyc <= cyc + 1;
    power_mode_and_reset_control dut_u (.clock_in, .rst_n_in, .psel_in, .penable_in,
        .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out,
        .reset_pin_in, .ext_int_n_in, .ext_code_in, .irq_wake_in, .timed_access_open_in,
        .wdt_timeout_in, .wdt_clear_in, .ale_core_in, .store_strobe_core_in,
        .cpu_clock_en_out, .periph_clock_en_out, .core_reset_out, .reset_image_out,
        .pin_ctrl_out, .wdt_restart_out, .machine_state_out);
    reset_pin_model pin_u (.clock_in, .reset_pin_out(reset_pin_in), .ext_int_n_out(ext_int_n_in));
    // ****************************************
    // shared tasks
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic ran_out();
        error_cnt++;
        $display("[ERR] %0t wait ran out", $time);
        give_verdict();
    endtask
    // request held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clock_in);
        psel_in <= 1'h1;
        pwrite_in <= wr;
        paddr_in <= a;
        pwdata_in <= {24'h0, d};
        @(posedge clock_in);
        penable_in <= 1'h1;
        do begin
            @(posedge clock_in);
            n++;
            if (n > 20) ran_out();
        end while (pready_out !== 1'h1);
        rd = prdata_out;
        err = pslverr_out;
        psel_in <= 1'h0;
        penable_in <= 1'h0;
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'h0, a, 8'h00);
        chk(rd, exp);
    endtask
    // which 0 watches internal reset, 1 the peripheral clock enable
    task automatic wait_sig(input int which, input logic lvl, input int lim);
        logic s;
        seen = 0;
        do begin
            @(negedge clock_in);
            seen++;
            s = (which == 0) ? core_reset_out : periph_clock_en_out;
            if (seen > lim) ran_out();
        end while (s !== lvl);
    endtask
    // {cpu clock, peripheral clock, pins}, sampled once the mode edge landed
    task automatic see_mode(input logic [6:0] exp);
        repeat (2) @(negedge clock_in);
        chk({25'h0, cpu_clock_en_out, periph_clock_en_out, pin_ctrl_out}, {25'h0, exp});
    endtask
    task automatic pin_reset();
        pin_u.hold_reset(16);
        chk({31'h0, core_reset_out}, 32'h1);
        wait_sig(0, 1'h0, 30);
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_regs();
        rdchk(A_WC, 32'h40);
        rdchk(A_PC, 32'h0);
        apb(1'h0, 12'h004, 8'h00);
        chk({31'h0, err}, 32'h1);
        see_mode(7'h70);
        $display("regs done");
    endtask
    task automatic t_access();
        apb(1'h1, A_WC, 8'hFF);
        rdchk(A_WC, 32'hC4);
        timed_access_open_in <= 1'h1;
        apb(1'h1, A_WC, 8'h03);
        timed_access_open_in <= 1'h0;
        rdchk(A_WC, 32'h02);
        apb(1'h1, A_WC, 8'h86);
        rdchk(A_WC, 32'h86);
        $display("access done");
    endtask
    task automatic t_idle();
        ext_code_in <= 1'h1;
        apb(1'h1, A_PC, 8'h01);
        see_mode(7'h3F);
        rdchk(A_PC, 32'h01);
        @(posedge clock_in);
        irq_wake_in <= 1'h1;
        @(posedge clock_in);
        irq_wake_in <= 1'h0;
        see_mode(7'h70);
        rdchk(A_PC, 32'h0);
        $display("idle done");
    endtask
    task automatic t_idle_reset();
        apb(1'h1, A_PC, 8'h01);
        pin_reset();
        see_mode(7'h70);
        rdchk(A_PC, 32'h0);
        rdchk(A_WC, 32'h06);
        $display("idle reset done");
    endtask
    task automatic t_pd();
        apb(1'h1, A_PC, 8'h02);
        see_mode(7'h02);
        pin_reset();
        see_mode(7'h70);
        rdchk(A_PC, 32'h0);
        apb(1'h1, A_WK, 8'h81);
        apb(1'h1, A_PC, 8'h02);
        pin_u.pull_int(1, 8);
        see_mode(7'h02);
        pin_u.pull_int(0, 8);
        wait_sig(1, 1'h1, 30);
        see_mode(7'h70);
        apb(1'h1, A_WK, 8'h8A);
        apb(1'h1, A_PC, 8'h02);
        pin_u.pull_int(1, 8);
        see_mode(7'h70);
        $display("power-down done");
    endtask
    task automatic t_wdt();
        apb(1'h1, A_WC, 8'h02);
        @(posedge clock_in);
        wdt_timeout_in <= 1'h1;
        @(posedge clock_in);
        wdt_timeout_in <= 1'h0;
        t0 = cyc;
        rdchk(A_WC, 32'h0A);
        wait_sig(0, 1'h1, 600);
        chk(32'(cyc - t0 >= 512 && cyc - t0 <= 515), 32'h1);
        wait_sig(0, 1'h0, 30);
        chk(32'(seen), 32'd8);
        rdchk(A_WC, 32'h06);
        $display("watchdog done");
    endtask
    task automatic t_por();
        @(posedge clock_in);
        rst_n_in <= 1'h0;
        repeat (2) @(posedge clock_in);
        rst_n_in <= 1'h1;
        rdchk(A_WC, 32'h40);
        rdchk(A_PC, 32'h0);
        $display("power-on done");
    endtask
    initial begin
        repeat (2) @(posedge clock_in);
        rst_n_in <= 1'h1;
        t_regs();
        t_access();
        t_idle();
        t_idle_reset();
        t_pd();
        t_wdt();
        t_por();
        give_verdict();
    end
endmodule
bind power_mode_and_reset_control power_reset_checker chk_u (.clock_in, .rst_n_in, .psel_in,
    .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .pready_out, .reset_pin_in, .irq_wake_in,
    .timed_access_open_in, .cpu_clock_en_out, .periph_clock_en_out, .core_reset_out,
    .reset_image_out, .pin_ctrl_out, .wdt_restart_out, .machine_state_out);
